/* src/cdsc_top.sv */
// Purpose: CAN debug suspend control, node-selective and clock stop
// Assumes: Core signals and bus strobes synchronous to mclk
// Notes:   module_clk_run gates the CAN kernel clock outside this block
//
// Behaviour
// - Each node has own suspend sensitivity bit
// - Suspended node forced into init when quiet
// - Running frame completes, no new frame
// - Clock runs, registers stay accessible
// - Acknowledge set once node is quiet
// - Upper mode bit stops kernel clock
// - Clock stop halts activity mid-frame
// - Clock stop drives transmit lines recessive
// - No writes, few reads while clock stopped
module cdsc_top (
  input  wire logic                           mclk,
  input  wire logic                           nrst,
  input  wire cdsc_pkg::cdsc_bus_s            bus,
  output logic      [cdsc_pkg::DW-1:0]        rdata,
  input  wire logic                           debug_suspend_req,
  input  wire logic [cdsc_pkg::NODES-1:0]     node_bus_idle,
  input  wire logic [cdsc_pkg::NODES-1:0]     node_bus_off,
  input  wire logic [cdsc_pkg::NODES-1:0]     core_txd,
  output logic      [cdsc_pkg::NODES-1:0]     txd,
  output logic      [cdsc_pkg::NODES-1:0]     node_init,
  output logic      [cdsc_pkg::NODES-1:0]     suspend_acknowledge,
  output logic                                module_clk_run,
  output logic                                irq
);

  cdsc_pkg::cdsc_top_s               q;
  cdsc_pkg::cdsc_top_s               d;
  logic [cdsc_pkg::NODES-1:0]        ack;
  logic [cdsc_pkg::NODES-1:0]        init_eff;
  logic [cdsc_pkg::IRQ_W-1:0]        irq_set;
  logic [cdsc_pkg::IRQ_W-1:0]        irq_status;
  logic [cdsc_pkg::IRQ_W-1:0]        irq_mask;
  logic                              stop_now;
  logic                              acc_ok;
  logic                              wr_ok;
  logic                              rd_ok;
  logic                              irq_clr_wr;
  logic                              irq_mask_wr;
  logic [cdsc_pkg::NODES-1:0]        ncr_hit;

  //////////////////////////////////////////////////////////////////////
  // Clock stop request
  assign stop_now = debug_suspend_req && q.suspend_mode_config[cdsc_pkg::SUSPEND_MODE_CONFIG_STOP];

  // Writes, mask reads and node control reads only while the kernel clock runs
  assign acc_ok = q.clk_run;
  assign wr_ok  = bus.wr && acc_ok;
  assign rd_ok  = bus.rd;

  //////////////////////////////////////////////////////////////////////
  // Node control register decode
  always_comb begin
    for (int i = 0; i < cdsc_pkg::NODES; i++) begin
      ncr_hit[i] = (bus.addr == cdsc_pkg::ADDR_NCR_BASE
                   + cdsc_pkg::AW'(i) * cdsc_pkg::ADDR_STRIDE);
    end
  end

  assign irq_clr_wr  = wr_ok && (bus.addr == cdsc_pkg::ADDR_IRQ_STAT);
  assign irq_mask_wr = wr_ok && (bus.addr == cdsc_pkg::ADDR_IRQ_MASK);

  //////////////////////////////////////////////////////////////////////
  // Interrupt events
  always_comb begin
    irq_set = '0;
    for (int i = 0; i < cdsc_pkg::NODES; i++) begin
      irq_set[i] = ack[i] && !q.ack_prev[i];
    end
    irq_set[cdsc_pkg::IRQ_STOP] = stop_now && q.clk_run;
  end

  //////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d          = q;
    d.rdata    = '0;
    d.ack_prev = ack;

    // Kernel clock gate
    d.clk_run = !stop_now;

    // Transmit lines
    for (int i = 0; i < cdsc_pkg::NODES; i++) begin
      if (stop_now) begin
        d.txd[i] = cdsc_pkg::TXD_REC;
      end else begin
        d.txd[i] = core_txd[i];
      end
    end

    // Register writes
    if (wr_ok) begin
      if (bus.addr == cdsc_pkg::ADDR_KSCFG) begin
        d.suspend_mode_config = bus.wdata[cdsc_pkg::SUSPEND_MODE_CONFIG_LSB +: cdsc_pkg::SUSPEND_MODE_CONFIG_W];
      end
      for (int i = 0; i < cdsc_pkg::NODES; i++) begin
        if (ncr_hit[i]) begin
          d.sw_init[i] = bus.wdata[cdsc_pkg::NCR_INIT];
          d.suspend_sensitivity_enable[i]   = bus.wdata[cdsc_pkg::NCR_SUSPEND_SENSITIVITY_ENABLE];
        end
      end
    end

    // Register reads
    if (rd_ok) begin
      case (bus.addr)
        cdsc_pkg::ADDR_KSCFG: begin
          d.rdata[cdsc_pkg::SUSPEND_MODE_CONFIG_LSB +: cdsc_pkg::SUSPEND_MODE_CONFIG_W] = q.suspend_mode_config;
          d.rdata[cdsc_pkg::KSCFG_RUN] = q.clk_run;
        end
        cdsc_pkg::ADDR_IRQ_STAT: begin
          d.rdata[cdsc_pkg::IRQ_W-1:0] = irq_status;
        end
        cdsc_pkg::ADDR_IRQ_MASK: begin
          if (acc_ok) begin
            d.rdata[cdsc_pkg::IRQ_W-1:0] = irq_mask;
          end
        end
        default: begin
          for (int i = 0; i < cdsc_pkg::NODES; i++) begin
            if (ncr_hit[i] && acc_ok) begin
              d.rdata[cdsc_pkg::NCR_INIT]    = q.sw_init[i];
              d.rdata[cdsc_pkg::NCR_SUSPEND_SENSITIVITY_ENABLE]   = q.suspend_sensitivity_enable[i];
              d.rdata[cdsc_pkg::NCR_SUSPEND_ACKNOWLEDGE]  = ack[i];
              d.rdata[cdsc_pkg::NCR_INITEFF] = init_eff[i];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      q <= cdsc_pkg::TOP_RST;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Per-node suspend sequencers
  // Node-selective suspend keeps working in any mode; with the stop
  // bit set the kernel clock is gone before a node can drain.
  for (genvar g = 0; g < cdsc_pkg::NODES; g++) begin : g_node
    cdsc_node u_node (
      .mclk        (mclk),
      .nrst        (nrst),
      .suspend_req (debug_suspend_req),
      .suspend_sensitivity_enable       (q.suspend_sensitivity_enable[g]),
      .sw_init     (q.sw_init[g]),
      .bus_idle    (node_bus_idle[g]),
      .bus_off     (node_bus_off[g]),
      .init_eff    (init_eff[g]),
      .ack         (ack[g])
    );
  end

  //////////////////////////////////////////////////////////////////////
  // Event flags and interrupt
  cdsc_irq u_irq (
    .mclk    (mclk),
    .nrst    (nrst),
    .set     (irq_set),
    .clr_wr  (irq_clr_wr),
    .mask_wr (irq_mask_wr),
    .wdata   (bus.wdata[cdsc_pkg::IRQ_W-1:0]),
    .status  (irq_status),
    .mask    (irq_mask),
    .irq     (irq)
  );

  //////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata               = q.rdata;
  assign txd                 = q.txd;
  assign node_init           = init_eff;
  assign suspend_acknowledge = ack;
  assign module_clk_run      = q.clk_run;

  //////////////////////////////////////////////////////////////////////
  // Checks
  a_clock_stop_now: assert property (@(posedge mclk) disable iff (!nrst)
    debug_suspend_req && q.suspend_mode_config[cdsc_pkg::SUSPEND_MODE_CONFIG_STOP] |=> !module_clk_run)
    else $error("kernel clock not stopped");

  a_clock_keeps_run: assert property (@(posedge mclk) disable iff (!nrst)
    !q.suspend_mode_config[cdsc_pkg::SUSPEND_MODE_CONFIG_STOP] && !bus.wr |=> module_clk_run)
    else $error("kernel clock stopped without stop mode");

  a_txd_recessive: assert property (@(posedge mclk) disable iff (!nrst)
    !module_clk_run |-> txd == {cdsc_pkg::NODES{cdsc_pkg::TXD_REC}})
    else $error("transmit line not recessive while stopped");

  a_txd_follows: assert property (@(posedge mclk) disable iff (!nrst)
    !stop_now |=> txd == $past(core_txd))
    else $error("transmit line not following core");

  a_suspend_sensitivity_enable_write: assert property (@(posedge mclk) disable iff (!nrst)
    module_clk_run && bus.wr && bus.addr == cdsc_pkg::ADDR_NCR_BASE
    |=> q.suspend_sensitivity_enable[0] == $past(bus.wdata[cdsc_pkg::NCR_SUSPEND_SENSITIVITY_ENABLE])
        && $stable(q.suspend_sensitivity_enable[1]))
    else $error("sensitivity write lost or spilled");

  a_stopped_no_write: assert property (@(posedge mclk) disable iff (!nrst)
    !module_clk_run && bus.wr |=> $stable(q.suspend_mode_config) && $stable(q.suspend_sensitivity_enable)
                                  && $stable(q.sw_init))
    else $error("write taken while clock stopped");

  a_cfg_read_back: assert property (@(posedge mclk) disable iff (!nrst)
    bus.rd && bus.addr == cdsc_pkg::ADDR_KSCFG
    |=> rdata[cdsc_pkg::SUSPEND_MODE_CONFIG_LSB +: cdsc_pkg::SUSPEND_MODE_CONFIG_W] == $past(q.suspend_mode_config))
    else $error("mode field read back wrong");

endmodule

/* src/cdsc_pkg.sv */
// Purpose: Shared constants and types for CAN debug suspend control
// Assumes: One module clock, synchronous active-low reset
// Notes:   Byte addresses on a plain register port, 32-bit data
package cdsc_pkg;

  localparam int NODES = 2;
  localparam int AW    = 8;
  localparam int DW    = 32;
  localparam int IRQ_W = NODES + 1;

  //////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [AW-1:0] ADDR_KSCFG     = 8'h00;
  localparam logic [AW-1:0] ADDR_NCR_BASE  = 8'h04;
  localparam logic [AW-1:0] ADDR_STRIDE    = 8'h04;
  localparam logic [AW-1:0] ADDR_IRQ_STAT  = 8'h10;
  localparam logic [AW-1:0] ADDR_IRQ_MASK  = 8'h14;

  // Kernel state config fields
  localparam int SUSPEND_MODE_CONFIG_LSB  = 0;
  localparam int SUSPEND_MODE_CONFIG_W    = 2;
  localparam int SUSPEND_MODE_CONFIG_STOP = 1;
  localparam int KSCFG_RUN   = 2;

  // Node control fields
  localparam int NCR_INIT    = 0;
  localparam int NCR_SUSPEND_SENSITIVITY_ENABLE   = 1;
  localparam int NCR_SUSPEND_ACKNOWLEDGE  = 2;
  localparam int NCR_INITEFF = 3;

  // Interrupt bit of the clock stop event
  localparam int IRQ_STOP = NODES;

  // Reset values
  localparam logic [SUSPEND_MODE_CONFIG_W-1:0] SUSPEND_MODE_CONFIG_RST = 2'h0;
  localparam logic [NODES-1:0]    INIT_RST   = 2'h3;
  localparam logic [NODES-1:0]    SUSPEND_SENSITIVITY_ENABLE_RST  = 2'h0;
  localparam logic                TXD_REC    = 1'h1;

  //////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } cdsc_bus_s;

  typedef enum logic [1:0] {
    NODE_RUN,
    NODE_DRAIN,
    NODE_HALT
  } cdsc_node_e;

  typedef struct packed {
    cdsc_node_e st;
    logic       init_eff;
    logic       ack;
  } cdsc_node_s;

  typedef struct packed {
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] mask;
    logic             irq;
  } cdsc_irq_s;

  typedef struct packed {
    logic [SUSPEND_MODE_CONFIG_W-1:0] suspend_mode_config;
    logic [NODES-1:0]    sw_init;
    logic [NODES-1:0]    suspend_sensitivity_enable;
    logic [DW-1:0]       rdata;
    logic [NODES-1:0]    txd;
    logic                clk_run;
    logic [NODES-1:0]    ack_prev;
  } cdsc_top_s;

  localparam cdsc_top_s TOP_RST = '{
    suspend_mode_config:   SUSPEND_MODE_CONFIG_RST,
    sw_init:  INIT_RST,
    suspend_sensitivity_enable:    SUSPEND_SENSITIVITY_ENABLE_RST,
    rdata:    32'h0,
    txd:      2'h3,
    clk_run:  1'h1,
    ack_prev: 2'h0
  };

endpackage

/* src/cdsc_node.sv */
// Purpose: Per-node suspend sequencing
// Assumes: bus_idle and bus_off come from the node's protocol engine
// Notes:   One instance per CAN node
module cdsc_node (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic suspend_req,
  input  wire logic suspend_sensitivity_enable,
  input  wire logic sw_init,
  input  wire logic bus_idle,
  input  wire logic bus_off,
  output logic      init_eff,
  output logic      ack
);

  cdsc_pkg::cdsc_node_s q;
  cdsc_pkg::cdsc_node_s d;
  logic                 want;
  logic                 quiet;

  assign want  = suspend_sensitivity_enable && suspend_req;
  assign quiet = bus_idle || bus_off;

  //////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    case (q.st)
      cdsc_pkg::NODE_RUN: begin
        if (want && quiet) begin
          d.st = cdsc_pkg::NODE_HALT;
        end else if (want) begin
          d.st = cdsc_pkg::NODE_DRAIN;
        end
      end
      cdsc_pkg::NODE_DRAIN: begin
        if (!want) begin
          d.st = cdsc_pkg::NODE_RUN;
        end else if (quiet) begin
          d.st = cdsc_pkg::NODE_HALT;
        end
      end
      cdsc_pkg::NODE_HALT: begin
        if (!want) begin
          d.st = cdsc_pkg::NODE_RUN;
        end
      end
      default: begin
        d.st = cdsc_pkg::NODE_RUN;
      end
    endcase
    d.ack      = (d.st == cdsc_pkg::NODE_HALT);
    d.init_eff = sw_init || d.ack;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      q <= '{st: cdsc_pkg::NODE_RUN, init_eff: 1'h1, ack: 1'h0};
    end else begin
      q <= d;
    end
  end

  assign init_eff = q.init_eff;
  assign ack      = q.ack;

  //////////////////////////////////////////////////////////////////////
  // Checks
  a_halt_when_quiet: assert property (@(posedge mclk) disable iff (!nrst)
    want && quiet |=> ack && init_eff)
    else $error("node not halted at bus idle");
  a_frame_completes: assert property (@(posedge mclk) disable iff (!nrst)
    want && !quiet && !ack |=> !ack)
    else $error("node halted inside a frame");
  a_ack_has_cause: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(ack) |-> $past(want) && $past(quiet))
    else $error("acknowledge without quiet bus");

endmodule

/* src/cdsc_irq.sv */
// Purpose: Sticky event flags, mask and interrupt line
// Assumes: Clear by writing one; set wins over clear
// Notes:   Interrupt output is registered
module cdsc_irq (
  input  wire logic                      mclk,
  input  wire logic                      nrst,
  input  wire logic [cdsc_pkg::IRQ_W-1:0] set,
  input  wire logic                      clr_wr,
  input  wire logic                      mask_wr,
  input  wire logic [cdsc_pkg::IRQ_W-1:0] wdata,
  output logic      [cdsc_pkg::IRQ_W-1:0] status,
  output logic      [cdsc_pkg::IRQ_W-1:0] mask,
  output logic                           irq
);

  cdsc_pkg::cdsc_irq_s q;
  cdsc_pkg::cdsc_irq_s d;

  always_comb begin
    d = q;
    if (clr_wr) begin
      d.status = q.status & ~wdata;
    end
    d.status = d.status | set;
    if (mask_wr) begin
      d.mask = wdata;
    end
    d.irq = |(d.status & d.mask);
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign status = q.status;
  assign mask   = q.mask;
  assign irq    = q.irq;

endmodule

/* testbench/cdsc_can_model.sv */
// Purpose: Protocol engine stand-in for each CAN node
// Assumes: A frame is FRAME_LEN cycles of dominant level
// Notes:   Kernel clock gating freezes the frame counter
module cdsc_can_model #(
  parameter int FRAME_LEN = 12
) (
  input  wire logic                          mclk,
  input  wire logic                          nrst,
  input  wire logic                          run,
  input  wire logic [cdsc_pkg::NODES-1:0]    start,
  input  wire logic [cdsc_pkg::NODES-1:0]    init,
  output logic      [cdsc_pkg::NODES-1:0]    idle,
  output logic      [cdsc_pkg::NODES-1:0]    txd
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] cnt_q [cdsc_pkg::NODES];

  ////////////////////////////////////////////////////////////////////////
  // Frame counters, no new frame while in init
  always_ff @(posedge mclk) begin
    for (int i = 0; i < cdsc_pkg::NODES; i++) begin
      if (!nrst) begin
        cnt_q[i] <= 8'h00;
      end else if (run && cnt_q[i] != 8'h00) begin
        cnt_q[i] <= cnt_q[i] - 8'h01;
      end else if (run && start[i] && !init[i]) begin
        cnt_q[i] <= FRAME_LEN[7:0];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < cdsc_pkg::NODES; i++) begin
      idle[i] = (cnt_q[i] == 8'h00);
      txd[i]  = (cnt_q[i] == 8'h00);
    end
  end
endmodule

/* testbench/tb_cdsc_top.sv */
// Purpose: Self-checking bench for CAN debug suspend control
// Assumes: Register port as in the hand-over map
// Notes:   Node and clock stop suspend, interrupts, refused access
module tb_cdsc_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                mclk = 1'h0;
  logic                nrst = 1'h0;
  logic                req  = 1'h0;
  cdsc_pkg::cdsc_bus_s bus  = '0;
  logic [31:0]         rdata;
  logic [1:0]          off   = 2'h0;
  logic [1:0]          start = 2'h0;
  logic [1:0]          idle, ctxd, txd, ninit, ack;
  logic                run, irq;
  int                  n_errors   = 0;
  int                  n_compared = 0;

  always #50 mclk = ~mclk;

  cdsc_top cdsc_top_i (
    .mclk(mclk), .nrst(nrst), .bus(bus), .rdata(rdata), .debug_suspend_req(req),
    .node_bus_idle(idle), .node_bus_off(off), .core_txd(ctxd), .txd(txd),
    .node_init(ninit), .suspend_acknowledge(ack), .module_clk_run(run), .irq(irq)
  );

  cdsc_can_model #(.FRAME_LEN(12)) cdsc_can_model_i (
    .mclk(mclk), .nrst(nrst), .run(run), .start(start), .init(ninit),
    .idle(idle), .txd(ctxd)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checking and access tasks
  task automatic conclude();
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    chk_reg({28'h0, got}, {28'h0, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'h1;
    @(posedge mclk);
    bus.wr    <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd   <= 1'h1;
    @(posedge mclk);
    bus.rd   <= 1'h0;
    @(negedge mclk);
    chk_reg(rdata, exp);
  endtask

  task automatic settle();
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic wait_ack(input logic [1:0] exp);
    int k;
    k = 0;
    while (ack !== exp && k < 60) begin
      @(negedge mclk);
      k++;
    end
    chk_pin({2'h0, ack}, {2'h0, exp});
    if (k >= 60) conclude();
  endtask

  task automatic do_reset();
    @(posedge mclk);
    nrst <= 1'h0;
    repeat (8) @(posedge mclk);
    nrst <= 1'h1;
    @(negedge mclk);
    chk_pin({txd, ninit}, 4'hf);
    chk_pin({run, irq, ack}, 4'h8);
    rd(8'h00, 32'h4);
    rd(8'h04, 32'h9);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    do_reset();
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h2);
    wr(8'h14, 32'h0);
    rd(8'h04, 32'h2);
    rd(8'h20, 32'h0);
    @(posedge mclk);
    start <= 2'h3;
    @(posedge mclk);
    start <= 2'h0;
    settle();
    chk_pin({2'h0, txd}, 4'h0);
    @(posedge mclk);
    req <= 1'h1;
    off <= 2'h2;
    settle();
    chk_pin({ninit, ack}, 4'ha);
    wait_ack(2'h3);
    chk_pin({2'h0, ninit}, 4'h3);
    rd(8'h04, 32'he);
    rd(8'h10, 32'h3);
    chk_pin({3'h0, irq}, 4'h0);
    wr(8'h14, 32'h7);
    settle();
    chk_pin({3'h0, irq}, 4'h1);
    wr(8'h10, 32'h3);
    rd(8'h10, 32'h0);
    settle();
    chk_pin({3'h0, irq}, 4'h0);
    @(posedge mclk);
    req <= 1'h0;
    off <= 2'h0;
    settle();
    chk_pin({ninit, ack}, 4'h0);
    wr(8'h00, 32'h2);
    @(posedge mclk);
    start <= 2'h3;
    @(posedge mclk);
    start <= 2'h0;
    settle();
    @(posedge mclk);
    req <= 1'h1;
    @(posedge mclk);
    @(negedge mclk);
    chk_pin({run, 1'h0, txd}, 4'h3);
    rd(8'h00, 32'h2);
    rd(8'h10, 32'h4);
    chk_pin({3'h0, irq}, 4'h1);
    wr(8'h04, 32'h0);
    rd(8'h04, 32'h0);
    settle();
    chk_pin({2'h0, txd}, 4'h3);
    @(posedge mclk);
    req <= 1'h0;
    settle();
    chk_pin({3'h0, run}, 4'h1);
    rd(8'h04, 32'h2);
    do_reset();
    conclude();
  end
endmodule
